// file: design/pdm_pkg.sv
// Package for the power-down and reference-miss register bank.
// Assumes byte-wide host register access at 16-bit byte addresses.
package pdm_pkg;

    localparam int ADDR_W = 16;
    localparam int DATA_W = 8;
    localparam int NUM_REF = 2;
    localparam int NUM_OUT = 8;
    localparam int THR_W = 17;

    localparam logic [ADDR_W-1:0] OFS_XTAL_DBL = 16'h00b4;
    localparam logic [ADDR_W-1:0] OFS_REF_OFF = 16'h00b5;
    localparam logic [ADDR_W-1:0] OFS_ALOOP_OFF = 16'h00b6;
    localparam logic [ADDR_W-1:0] OFS_OUT_OFF = 16'h00b7;
    localparam logic [ADDR_W-1:0] OFS_DLOOP_CAL = 16'h00b8;
    localparam logic [ADDR_W-1:0] OFS_REF0_THR_HI = 16'h00b9;
    localparam logic [ADDR_W-1:0] OFS_REF0_THR_MID = 16'h00ba;
    localparam logic [ADDR_W-1:0] OFS_REF0_THR_LO = 16'h00bb;
    localparam logic [ADDR_W-1:0] OFS_REF1_THR_HI = 16'h00bc;
    localparam logic [ADDR_W-1:0] OFS_REF1_THR_MID = 16'h00bd;
    localparam logic [ADDR_W-1:0] OFS_REF1_THR_LO = 16'h00be;

    // Field positions
    localparam int BIT_XTAL_BYPASS = 0;
    localparam int BIT_ALOOP1_OFF = 4;
    localparam int BIT_CAL_HOLD0 = 0;
    localparam int BIT_DLOOP_OFF0 = 2;
    localparam int BIT_THR_HI = 0;
    localparam int THR_HI_POS = 16;
    localparam int THR_MID_LSB = 8;
    localparam int THR_LO_LSB = 0;

    localparam logic [THR_W-1:0] THR_RESET = 17'h1ffff;
    localparam logic [THR_W-1:0] CNT_ZERO = 17'h00000;
    localparam logic [THR_W-1:0] CNT_ONE = 17'h00001;
    localparam logic [DATA_W-1:0] RD_ZERO = 8'h00;

    typedef struct packed {
        logic xtal_doubler_bypass;
        logic [NUM_REF-1:0] ref_input_off;
        logic analog_loop1_off;
        logic [NUM_OUT-1:0] output_driver_off;
        logic [NUM_REF-1:0] digital_loop_off;
        logic [NUM_REF-1:0] analog_loop_cal_hold;
    } pdm_ctrl_s;

    localparam pdm_ctrl_s CTRL_RESET = '0;

endpackage : pdm_pkg

// file: design/pdm_regs.sv
// Power-down controls and per-reference missing-signal monitor.
// Assumes a one-cycle host strobe port; ref pins are asynchronous.
// Operation
// RULE1 - Bypass bit 0 feeds doubled crystal to both loops, 1 feeds it undoubled.
// RULE2 - Each reference input has a disable bit, 1 disables it and 0 enables it.
// RULE3 - The second analog loop's disable bit shuts that loop off when 1.
// RULE4 - Each of eight outputs has a disable bit that kills its logic and tri-states it.
// RULE5 - Each digital loop has a disable bit, 1 disables it and 0 enables it.
// RULE6 - Each analog loop has a calibration hold bit, 1 holds calibration off.
// RULE7 - Each reference has a 17-bit threshold resetting to all ones; a miss alarm rises after that many idle periods.
// RULE8 - Software programs every threshold to three or more.
// RULE9 - Software writes zero to every reserved bit.
// RULE10 - Software ignores the value read from reserved bits.
// RULE11 - A reference's period counter restarts on each detected edge and compares all 17 bits.
`timescale 1ns/1ps

module pdm_regs
    import pdm_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    output logic [DATA_W-1:0] reg_rdata,
    output logic reg_rvalid,
    input wire logic [NUM_REF-1:0] ref_in,
    output pdm_ctrl_s ctrl,
    output logic [NUM_OUT-1:0] out_oe,
    output logic xtal_mult_two,
    output logic [NUM_REF-1:0] ref_miss
);

    pdm_ctrl_s ctrl_r;
    logic [THR_W-1:0] thr_r [NUM_REF];
    logic [THR_W-1:0] cnt_r [NUM_REF];
    logic [NUM_REF-1:0] s1_r, s2_r, s3_r, filt_r, miss_r;
    logic [NUM_REF-1:0] edge_w;
    logic [NUM_REF-1:0] filt_nxt;
    logic [DATA_W-1:0] rdata_r;
    logic rvalid_r;
    logic [NUM_OUT-1:0] oe_r;
    logic mult_r;
    logic [2:0] sel_w;

    // Which threshold byte an address selects: bit0 ref, bits 2:1 = 1 hi,2 mid,3 lo
    function automatic logic [2:0] thr_sel(input logic [ADDR_W-1:0] a);
        logic [2:0] s;
        s = 3'h0;
        case (a)
            OFS_REF0_THR_HI: s = 3'h2;
            OFS_REF0_THR_MID: s = 3'h4;
            OFS_REF0_THR_LO: s = 3'h6;
            OFS_REF1_THR_HI: s = 3'h3;
            OFS_REF1_THR_MID: s = 3'h5;
            OFS_REF1_THR_LO: s = 3'h7;
            default: s = 3'h0;
        endcase
        return s;
    endfunction : thr_sel

    // Decoded once; a function result cannot be bit-selected directly
    assign sel_w = thr_sel(reg_addr);

    // Control bits; reserved bits are not stored
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ctrl_r <= CTRL_RESET;
        end
        else if (reg_wr)
        begin
            case (reg_addr)
                OFS_XTAL_DBL: ctrl_r.xtal_doubler_bypass <= reg_wdata[BIT_XTAL_BYPASS]; // RULE1
                OFS_REF_OFF: ctrl_r.ref_input_off <= reg_wdata[NUM_REF-1:0]; // RULE2
                OFS_ALOOP_OFF: ctrl_r.analog_loop1_off <= reg_wdata[BIT_ALOOP1_OFF]; // RULE3
                OFS_OUT_OFF: ctrl_r.output_driver_off <= reg_wdata; // RULE4
                OFS_DLOOP_CAL:
                begin
                    ctrl_r.digital_loop_off <= reg_wdata[BIT_DLOOP_OFF0 +: NUM_REF]; // RULE5
                    ctrl_r.analog_loop_cal_hold <= reg_wdata[BIT_CAL_HOLD0 +: NUM_REF]; // RULE6
                end
                default: ctrl_r <= ctrl_r;
            endcase
        end
    end

    // Derived pin-facing levels, registered so outputs come from flops
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            oe_r <= '0;
            mult_r <= 1'b1;
        end
        else
        begin
            oe_r <= ctrl_r.output_driver_off; // RULE4
            mult_r <= ~ctrl_r.xtal_doubler_bypass; // RULE1
        end
    end

    // Threshold bytes, assembled into 17 bits per reference
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            for (int i = 0; i < NUM_REF; i++)
            begin
                thr_r[i] <= THR_RESET; // RULE7
            end
        end
        else if (reg_wr && sel_w != 3'h0)
        begin
            case (sel_w[2:1])
                2'h1: thr_r[sel_w[0]][THR_HI_POS] <= reg_wdata[BIT_THR_HI]; // RULE11
                2'h2: thr_r[sel_w[0]][THR_MID_LSB +: DATA_W] <= reg_wdata; // RULE11
                default: thr_r[sel_w[0]][THR_LO_LSB +: DATA_W] <= reg_wdata; // RULE11
            endcase
        end
    end

    // Read port: one cycle after the strobe; reserved bits read zero
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rdata_r <= RD_ZERO;
            rvalid_r <= 1'b0;
        end
        else
        begin
            rvalid_r <= reg_rd;
            if (reg_rd)
            begin
                rdata_r <= RD_ZERO;
                case (reg_addr)
                    OFS_XTAL_DBL: rdata_r[BIT_XTAL_BYPASS] <= ctrl_r.xtal_doubler_bypass;
                    OFS_REF_OFF: rdata_r[NUM_REF-1:0] <= ctrl_r.ref_input_off;
                    OFS_ALOOP_OFF: rdata_r[BIT_ALOOP1_OFF] <= ctrl_r.analog_loop1_off;
                    OFS_OUT_OFF: rdata_r <= ctrl_r.output_driver_off;
                    OFS_DLOOP_CAL:
                    begin
                        rdata_r[BIT_DLOOP_OFF0 +: NUM_REF] <= ctrl_r.digital_loop_off;
                        rdata_r[BIT_CAL_HOLD0 +: NUM_REF] <= ctrl_r.analog_loop_cal_hold;
                    end
                    default:
                    begin
                        if (sel_w != 3'h0)
                        begin
                            case (sel_w[2:1])
                                2'h1: rdata_r[BIT_THR_HI] <= thr_r[sel_w[0]][THR_HI_POS];
                                2'h2: rdata_r <= thr_r[sel_w[0]][THR_MID_LSB +: DATA_W];
                                default: rdata_r <= thr_r[sel_w[0]][THR_LO_LSB +: DATA_W];
                            endcase
                        end
                    end
                endcase
            end
        end
    end

    // Reference synchronisers; a level is accepted once stages two and three agree
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
            filt_r <= '0;
        end
        else
        begin
            s1_r <= ref_in;
            s2_r <= s1_r;
            s3_r <= s2_r;
            filt_r <= filt_nxt;
        end
    end

    always_comb
    begin
        for (int i = 0; i < NUM_REF; i++)
        begin
            filt_nxt[i] = (s2_r[i] == s3_r[i]) ? s3_r[i] : filt_r[i];
            edge_w[i] = filt_nxt[i] & ~filt_r[i];
        end
    end

    // Period counters; a disabled reference neither counts nor alarms
    generate
        for (genvar g = 0; g < NUM_REF; g++)
        begin : g_mon
            always_ff @(posedge clk or negedge rst_n)
            begin
                if (!rst_n)
                begin
                    cnt_r[g] <= CNT_ZERO;
                    miss_r[g] <= 1'b0;
                end
                else if (ctrl_r.ref_input_off[g] || edge_w[g])
                begin
                    cnt_r[g] <= CNT_ZERO; // RULE11 RULE2
                    miss_r[g] <= 1'b0;
                end
                else
                begin
                    // Saturate so a dead reference keeps its alarm
                    if (cnt_r[g] != THR_RESET)
                    begin
                        cnt_r[g] <= cnt_r[g] + CNT_ONE;
                    end
                    miss_r[g] <= (cnt_r[g] >= thr_r[g]); // RULE7 RULE11
                end
            end

            chk_edge_restart: assert property ( // RULE11
                @(posedge clk) disable iff (!rst_n)
                edge_w[g] |=> cnt_r[g] == CNT_ZERO
            ) else $error("counter not restarted");

            chk_cnt_advance: assert property ( // RULE11
                @(posedge clk) disable iff (!rst_n)
                (!ctrl_r.ref_input_off[g] && !edge_w[g] && cnt_r[g] != THR_RESET)
                |=> cnt_r[g] == $past(cnt_r[g]) + CNT_ONE
            ) else $error("counter did not advance");

            chk_miss_rise: assert property ( // RULE7
                @(posedge clk) disable iff (!rst_n)
                (!ctrl_r.ref_input_off[g] && !edge_w[g] && cnt_r[g] >= thr_r[g])
                |=> miss_r[g]
            ) else $error("miss alarm late");

            // A threshold rewrite may legally drop the alarm, so only a steady one is held
            chk_miss_hold: assert property ( // RULE7
                @(posedge clk) disable iff (!rst_n)
                (miss_r[g] && !ctrl_r.ref_input_off[g] && !edge_w[g] && $stable(thr_r[g]))
                |=> miss_r[g]
            ) else $error("miss alarm dropped");

            chk_miss_cause: assert property ( // RULE7
                @(posedge clk) disable iff (!rst_n)
                $rose(miss_r[g]) |-> $past(cnt_r[g]) >= $past(thr_r[g])
            ) else $error("miss alarm early");

            chk_ref_disable: assert property ( // RULE2
                @(posedge clk) disable iff (!rst_n)
                ctrl_r.ref_input_off[g] |=> !miss_r[g] && cnt_r[g] == CNT_ZERO
            ) else $error("disabled ref still monitored");
        end
    endgenerate

    // Register-to-control checks
    chk_ref_off_store: assert property ( // RULE2
        @(posedge clk) disable iff (!rst_n)
        (reg_wr && reg_addr == OFS_REF_OFF)
        |=> ctrl.ref_input_off == $past(reg_wdata[NUM_REF-1:0])
    ) else $error("reference disable wrong");

    chk_doubler_path: assert property ( // RULE1
        @(posedge clk) disable iff (!rst_n)
        (reg_wr && reg_addr == OFS_XTAL_DBL)
        |=> ##1 mult_r == !$past(reg_wdata[BIT_XTAL_BYPASS], 2)
    ) else $error("doubler select wrong");

    chk_aloop_off: assert property ( // RULE3
        @(posedge clk) disable iff (!rst_n)
        (reg_wr && reg_addr == OFS_ALOOP_OFF)
        |=> ctrl.analog_loop1_off == $past(reg_wdata[BIT_ALOOP1_OFF])
    ) else $error("analog loop disable wrong");

    chk_out_hiz: assert property ( // RULE4
        @(posedge clk) disable iff (!rst_n)
        (reg_wr && reg_addr == OFS_OUT_OFF)
        |=> ##1 out_oe == $past(reg_wdata, 2)
    ) else $error("output disable wrong");

    chk_dloop_cal: assert property ( // RULE5 RULE6
        @(posedge clk) disable iff (!rst_n)
        (reg_wr && reg_addr == OFS_DLOOP_CAL) |=>
        ctrl.digital_loop_off == $past(reg_wdata[BIT_DLOOP_OFF0 +: NUM_REF]) &&
        ctrl.analog_loop_cal_hold == $past(reg_wdata[BIT_CAL_HOLD0 +: NUM_REF])
    ) else $error("loop control wrong");

    chk_thr_low_write: assert property ( // RULE7
        @(posedge clk) disable iff (!rst_n)
        (reg_wr && reg_addr == OFS_REF0_THR_LO)
        |=> thr_r[0][THR_LO_LSB +: DATA_W] == $past(reg_wdata)
    ) else $error("threshold low byte wrong");

    chk_thr_high_write: assert property ( // RULE11
        @(posedge clk) disable iff (!rst_n)
        (reg_wr && reg_addr == OFS_REF1_THR_HI)
        |=> thr_r[1][THR_HI_POS] == $past(reg_wdata[BIT_THR_HI])
    ) else $error("threshold top bit wrong");

    chk_thr_reset: assert property ( // RULE7
        @(posedge clk)
        $rose(rst_n) |-> thr_r[0] == THR_RESET && thr_r[1] == THR_RESET
    ) else $error("threshold reset value wrong");

    assign ctrl = ctrl_r;
    assign out_oe = oe_r;
    assign xtal_mult_two = mult_r;
    assign ref_miss = miss_r;
    assign reg_rdata = rdata_r;
    assign reg_rvalid = rvalid_r;

endmodule : pdm_regs

// file: verification/pdm_regs_tb.sv
// Self-checking bench for the power-down and reference-miss register bank.
// Assumes the design's one-cycle strobe port and a clk-driven miss monitor.
`timescale 1ns/1ps

module pdm_regs_tb;
    import pdm_pkg::*;

    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [ADDR_W-1:0] reg_addr = '0;
    logic [DATA_W-1:0] reg_wdata = '0;
    logic [DATA_W-1:0] reg_rdata;
    logic reg_rvalid;
    logic [NUM_REF-1:0] ref_in = '0;
    pdm_ctrl_s ctrl;
    pdm_ctrl_s exp_c;
    logic [NUM_OUT-1:0] out_oe;
    logic xtal_mult_two;
    logic [NUM_REF-1:0] ref_miss;
    logic [15:0] rd_q[$];
    logic [15:0] rd_note;
    logic [31:0] seed = 32'h51ef;
    logic [7:0] d[5];
    int n_mismatch = 0;
    int checks_done = 0;
    int n;

    always #5 clk = ~clk;

    pdm_regs dut_u (.clk(clk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .ref_in(ref_in), .ctrl(ctrl), .out_oe(out_oe),
        .xtal_mult_two(xtal_mult_two), .ref_miss(ref_miss));

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return (x >> 1) ^ (x[0] ? 32'h80200003 : 32'h0);
    endfunction : lfsr

    // Defined bits per address; reserved bits are never relied upon
    function automatic logic [7:0] msk(input logic [7:0] a);
        case (a)
            8'hb4, 8'hb9, 8'hbc: return 8'h01;
            8'hb5: return 8'h03;
            8'hb6: return 8'h10;
            8'hb8: return 8'h0f;
            8'hb7, 8'hba, 8'hbb, 8'hbd, 8'hbe: return 8'hff;
            default: return 8'h00;
        endcase
    endfunction : msk

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic tally_and_finish;
        $display("checks_done=%0d n_mismatch=%0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : tally_and_finish

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(negedge clk);
        reg_wr = 1'b1;
        reg_addr = {8'h00, a};
        reg_wdata = v & msk(a);
        @(negedge clk);
        reg_wr = 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] v);
        @(negedge clk);
        reg_rd = 1'b1;
        reg_addr = {8'h00, a};
        rd_q.push_back({msk(a), v});
        @(negedge clk);
        reg_rd = 1'b0;
    endtask : rd

    // Read results are paired with the oldest note; reserved bits are masked
    // Sampled mid-cycle, where the registered answer has settled
    always @(negedge clk)
    begin
        if (reg_rvalid === 1'b1)
        begin
            if (rd_q.size() == 0)
                check(1, 0);
            else
            begin
                rd_note = rd_q.pop_front();
                check(reg_rdata & rd_note[15:8], rd_note[7:0] & rd_note[15:8]);
            end
        end
    end

    // Low then high on one reference, each level long enough for the filter
    task automatic ref_pulse(input int i);
        @(negedge clk);
        ref_in[i] = 1'b0;
        repeat (4) @(negedge clk);
        ref_in[i] = 1'b1;
    endtask : ref_pulse

    // Cycles from a reference edge until its alarm rises; an alarm left from
    // before is ignored until the edge has had time to clear it
    task automatic miss_time(input int i, input int lim, output int cnt);
        ref_pulse(i);
        cnt = 0;
        while ((ref_miss[i] !== 1'b1 || cnt < 4) && cnt < lim)
        begin
            @(negedge clk);
            cnt++;
        end
    endtask : miss_time

    initial
    begin
        repeat (10) @(negedge clk);
        rst_n = 1'b1;
        check(ctrl, CTRL_RESET);
        check(xtal_mult_two, 1'b1);
        for (int a = 8'hb4; a <= 8'hbe; a++)
            rd(a[7:0], (a == 8'hb9 || a == 8'hbc) ? 8'h01 : (a > 8'hb9) ? 8'hff : 8'h00);
        rd(8'hc0, 8'h00);
        for (int k = 0; k < 6; k++)
        begin
            for (int j = 0; j < 5; j++)
            begin
                seed = lfsr(seed);
                d[j] = seed[7:0] & msk(8'hb4 + j[7:0]);
                wr(8'hb4 + j[7:0], d[j]);
            end
            repeat (3) @(negedge clk);
            exp_c = '{d[0][BIT_XTAL_BYPASS], d[1][1:0], d[2][BIT_ALOOP1_OFF], d[3],
                d[4][BIT_DLOOP_OFF0 +: 2], d[4][BIT_CAL_HOLD0 +: 2]};
            check(ctrl, exp_c);
            check(out_oe, d[3]);
            check(xtal_mult_two, !d[0][BIT_XTAL_BYPASS]);
            for (int j = 0; j < 5; j++)
                rd(8'hb4 + j[7:0], d[j]);
        end
        wr(8'hb5, 8'h00);
        wr(8'hb9, 8'h00);
        wr(8'hba, 8'h00);
        wr(8'hbb, 8'h03);
        rd(8'hbb, 8'h03);
        miss_time(0, 40, n);
        check(n >= 5 && n <= 11, 1'b1);
        ref_pulse(0);
        repeat (6) @(negedge clk);
        check(ref_miss[0], 1'b0);
        wr(8'hb5, 8'h01);
        repeat (30) @(negedge clk);
        check(ref_miss[0], 1'b0);
        wr(8'hb5, 8'h00);
        ref_pulse(1);
        repeat (300) @(negedge clk);
        check(ref_miss[1], 1'b0);
        wr(8'hbc, 8'h00);
        wr(8'hbd, 8'h01);
        wr(8'hbe, 8'h00);
        miss_time(1, 400, n);
        check(n >= 258 && n <= 264, 1'b1);
        repeat (5) @(negedge clk);
        check(rd_q.size(), 0);
        tally_and_finish();
    end

endmodule : pdm_regs_tb
